/* File: prs_pkg.sv */
// Shared constants for the protection restart sequencer
package prs_pkg;
  // Clock rate in MHz
  localparam int CLK_MHZ = 250;
  // Built-in overload blanking, input OVP blanking, spike blanking (us)
  localparam int BLANK_T_US = 20000;
  localparam int OVP_BLANK_T_US = 400;
  localparam int SPIKE_T_US = 30;
  localparam int BLANK_CYC = BLANK_T_US * CLK_MHZ;
  localparam int OVP_BLANK_CYC = OVP_BLANK_T_US * CLK_MHZ;
  localparam int SPIKE_CYC = SPIKE_T_US * CLK_MHZ;
  // Soft start window (us)
  localparam int SOFT_T_US = 10000;
  localparam int SOFT_CYC = SOFT_T_US * CLK_MHZ;
  // Extended blanking count target
  localparam logic [8:0] EXT_COUNT_END = 9'h100;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] COUNT_OFS = 12'h008;
  // Control fields and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  // Status field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ODD_BIT = 2;
  localparam int ST_OVP_BIT = 3;
  localparam int ST_OTP_BIT = 4;
  localparam int ST_DONE_BIT = 5;
  localparam int ST_SW_BIT = 6;
  localparam int ST_SOFT_BIT = 7;
  // Number of synchronised comparator inputs
  localparam int NFLAG = 10;
  // Restart behaviours
  typedef enum logic [1:0] {
    PRS_NONE,
    PRS_NORMAL,
    PRS_ODD_SKIP,
    PRS_NON_SWITCH
  } prs_mode_t;
endpackage

/* File: prs_sync.sv */
// Two-stage synchroniser for comparator flags
`timescale 1ns/1ps
module prs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flags
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: prs_ext_blank.sv */
// Extended overload blanking counter on the shared blanking pin
`timescale 1ns/1ps
module prs_ext_blank (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic blank_upper_cmp,
  input wire logic blank_lower_cmp,
  // Pin switches and result
  output logic charge_switch,
  output logic discharge_switch,
  output logic done,
  output logic [8:0] count
);
  import prs_pkg::*;
  typedef enum logic [1:0] {EB_IDLE, EB_DISCH, EB_CHG, EB_DONE} prs_eb_t;
  prs_eb_t st_reg, st_next;
  logic [8:0] cnt_next;
  logic at_end;

  assign at_end = (count + 9'h001) == EXT_COUNT_END;

  // Discharge to low mark, charge to high mark, count each rise
  always_comb begin
    st_next = st_reg;
    cnt_next = count;
    unique case (st_reg)
      EB_IDLE: if (run) st_next = EB_DISCH;
      EB_DISCH: if (blank_lower_cmp) st_next = EB_CHG;
      EB_CHG: begin
        if (blank_upper_cmp) begin
          cnt_next = count + 9'h001;
          st_next = at_end ? EB_DONE : EB_DISCH;
        end
      end
      EB_DONE: st_next = EB_DONE;
    endcase
    if (!run) begin
      st_next = EB_IDLE;
      cnt_next = '0;
    end
  end

  // State, count and registered pin drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= EB_IDLE;
      count <= '0;
      charge_switch <= 1'b0;
      discharge_switch <= 1'b0;
      done <= 1'b0;
    end else begin
      st_reg <= st_next;
      count <= cnt_next;
      charge_switch <= (st_next == EB_CHG);
      discharge_switch <= (st_next == EB_DISCH);
      done <= (st_next == EB_DONE);
    end
  end
endmodule

/* File: prs_top.sv */
// Protection restart sequencer with APB register access
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Three restart behaviours: normal, odd-skip, non-switching, chosen by fault.
// - Odd-skip: odd restart cycles neither evaluate faults nor switch.
// - Odd-skip: even cycles soft start and evaluate; exit only on even.
// - Non-switching: never switch in restart; evaluate and resume at even cycles.
// - Supply OVP, overload, open loop odd-skip; undervoltage normal; heat non-switching.
// - Supply above 20.5V with feedback above 4.5V in soft start: odd-skip.
// - Supply above 25.5V in soft start or run phase: odd-skip.
// - Above 130C non-switching; recover only 50C below trip.
// - Below 10.5V shut down, startup cell on; restart at 17V.
// - Feedback above 4.5V runs 20ms blanking, then extended counter.
// - Extended counter discharges to 0.9V, charges to 4.5V, counts, repeats.
// - At 256 counts done; overload still present gives odd-skip after 30us.
// - Without capacitor the count ends fast; blanking equals built-in 20ms.
// - Pin above 1.98V for 400us while supply on sets input OVP latch.
// - Input OVP latched: no switching in any cycle, keep monitoring pin.
// - Input OVP latch clears only below 1.91V.
// - After clear, soft start in next restart cycle at 17V.
// - Shared pin: first started function wins; recheck OVP after a skip cycle.
module prs_top #(
  parameter int BLANK_CYC_P = prs_pkg::BLANK_CYC,
  parameter int OVP_BLANK_CYC_P = prs_pkg::OVP_BLANK_CYC,
  parameter int SPIKE_CYC_P = prs_pkg::SPIKE_CYC,
  parameter int SOFT_CYC_P = prs_pkg::SOFT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator flags
  input wire logic supply_on_cmp,
  input wire logic vcc_ovp1_cmp,
  input wire logic vcc_ovp2_cmp,
  input wire logic feedback_high_cmp,
  input wire logic over_temp_cmp,
  input wire logic temp_recover_cmp,
  input wire logic blank_upper_cmp,
  input wire logic blank_lower_cmp,
  input wire logic ovp_set_cmp,
  input wire logic ovp_clear_cmp,
  // Power stage controls
  output logic switch_enable,
  output logic soft_start,
  output logic startup_cell_on,
  output logic charge_switch,
  output logic discharge_switch,
  // Status
  output prs_pkg::prs_mode_t restart_mode,
  output logic cycle_odd,
  output logic input_ovp_latch,
  output logic ext_blank_done
);
  import prs_pkg::*;

  typedef enum logic [1:0] {PH_OFF, PH_SOFT, PH_RUN, PH_HOLD} prs_phase_t;

  // Synchronised flags
  logic [NFLAG-1:0] raw_flags;
  logic [NFLAG-1:0] sflags;
  logic s_on, s_ovp1, s_ovp2, s_fbh, s_hot, s_cool, s_up, s_low, s_oset, s_oclr;
  // Sequencer state
  prs_phase_t phase_reg, phase_next;
  prs_mode_t mode_next;
  logic odd_next;
  logic on_d_reg;
  logic on_rise, on_fall;
  logic otp_reg;
  logic ctrl_en_reg;
  logic [31:0] phase_cnt_reg;
  logic [31:0] blank_cnt_reg;
  logic [31:0] ovp_cnt_reg;
  logic [31:0] spike_cnt_reg;
  logic active;
  logic ext_run;
  logic ext_done;
  logic ext_chg, ext_dis;
  logic [8:0] ext_count;
  logic blank_reached;
  logic ovp_qualified;
  logic fault_ovp1, fault_ovp2, fault_olp;
  logic fault_odd, fault_any;
  logic may_switch, even_eval;
  logic sw_next;
  logic ovp_latch_next;
  // Bus decode
  logic bus_access, bus_done, bus_write;
  logic hit_ctrl, hit_status, hit_count, hit_any;
  logic [31:0] status_word, read_word;

  // Comparator flags pass two flops before use
  assign raw_flags = {ovp_clear_cmp, ovp_set_cmp, blank_lower_cmp, blank_upper_cmp,
                      temp_recover_cmp, over_temp_cmp, feedback_high_cmp,
                      vcc_ovp2_cmp, vcc_ovp1_cmp, supply_on_cmp};
  prs_sync #(.W(NFLAG)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_flags),
    .sync_out(sflags)
  );
  assign {s_oclr, s_oset, s_low, s_up, s_cool, s_hot, s_fbh, s_ovp2, s_ovp1, s_on} = sflags;

  // Supply lockout edges
  // Edge flop resets low like the idle supply flag, so no false rise
  assign on_rise = s_on && !on_d_reg;
  assign on_fall = !s_on && on_d_reg;
  assign active = (phase_reg == PH_SOFT) || (phase_reg == PH_RUN);

  // Overload blanking chain
  assign blank_reached = blank_cnt_reg >= 32'(BLANK_CYC_P);
  // Extended blanking only takes the pin while no OVP blanking has begun
  assign ext_run = active && s_fbh && blank_reached && (ovp_cnt_reg == '0);
  prs_ext_blank u_ext (
    .pclk(pclk),
    .presetn(presetn),
    .run(ext_run),
    .blank_upper_cmp(s_up),
    .blank_lower_cmp(s_low),
    .charge_switch(ext_chg),
    .discharge_switch(ext_dis),
    .done(ext_done),
    .count(ext_count)
  );

  // Fault detection in active phases
  assign fault_ovp1 = (phase_reg == PH_SOFT) && s_ovp1 && s_fbh;
  assign fault_ovp2 = s_ovp2 && active;
  // Overload counts only once the spike blanking has run out
  assign fault_olp = ext_done && s_fbh && (spike_cnt_reg >= 32'(SPIKE_CYC_P));
  assign fault_odd = fault_ovp1 || fault_ovp2 || fault_olp;
  assign fault_any = fault_odd || otp_reg;
  assign ovp_qualified = ovp_cnt_reg >= 32'(OVP_BLANK_CYC_P);

  // Cycle gating by mode, parity and latches
  // Parity of the cycle a supply rise starts, from registered state only
  assign even_eval = (restart_mode == PRS_NONE) ? !cycle_odd : cycle_odd;
  assign may_switch = !input_ovp_latch && !otp_reg &&
                      ((restart_mode == PRS_NONE) || (restart_mode == PRS_NORMAL) ||
                       ((restart_mode == PRS_ODD_SKIP) && even_eval));

  // Phase sequencing and restart selection
  always_comb begin
    phase_next = phase_reg;
    mode_next = restart_mode;
    odd_next = cycle_odd;
    if (on_rise) begin
      if (restart_mode != PRS_NONE) begin
        odd_next = !cycle_odd;
      end
    end
    unique case (phase_reg)
      PH_OFF: begin
        if (on_rise) begin
          phase_next = may_switch ? PH_SOFT : PH_HOLD;
          // Heat gone at an even rise: soft start in this very cycle, or hold if the input OVP latch is set
          if (restart_mode == PRS_NON_SWITCH && even_eval && !otp_reg) begin
            mode_next = PRS_NONE;
            phase_next = input_ovp_latch ? PH_HOLD : PH_SOFT;
          end
        end
      end
      PH_SOFT: begin
        if (phase_cnt_reg >= 32'(SOFT_CYC_P)) begin
          phase_next = PH_RUN;
          // Soft start ended without fault: leave the restart loop
          if (restart_mode == PRS_ODD_SKIP || restart_mode == PRS_NORMAL) begin
            mode_next = PRS_NONE;
          end
        end
      end
      PH_RUN: phase_next = PH_RUN;
      PH_HOLD: phase_next = PH_HOLD;
    endcase
    if (active) begin
      if (otp_reg) begin
        mode_next = PRS_NON_SWITCH;
        phase_next = PH_HOLD;
      end else if (fault_odd || input_ovp_latch) begin
        if (fault_odd) begin
          mode_next = PRS_ODD_SKIP;
        end
        phase_next = PH_HOLD;
      end
      // A fresh fault makes the next restart cycle the first, odd one
      if (fault_any && (restart_mode == PRS_NONE || restart_mode == PRS_NORMAL)) begin
        odd_next = 1'b0;
      end
    end
    if (on_fall) begin
      phase_next = PH_OFF;
      if (active && !fault_any && restart_mode == PRS_NONE) begin
        mode_next = PRS_NORMAL;
      end
    end
  end

  // Next input OVP latch value; set wins over clear
  assign ovp_latch_next = (ovp_qualified && s_on) ? 1'b1 :
                          s_oclr ? 1'b0 : input_ovp_latch;

  // Gate follows the next latch value, so latch and gate change on one edge
  assign sw_next = ctrl_en_reg && (phase_next == PH_SOFT || phase_next == PH_RUN) &&
                   !ovp_latch_next;

  // Phase, mode, parity and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_OFF;
      restart_mode <= PRS_NONE;
      cycle_odd <= 1'b0;
      on_d_reg <= 1'b0;
      switch_enable <= 1'b0;
      soft_start <= 1'b0;
      startup_cell_on <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      restart_mode <= mode_next;
      cycle_odd <= odd_next;
      on_d_reg <= s_on;
      switch_enable <= sw_next;
      soft_start <= sw_next && (phase_next == PH_SOFT);
      startup_cell_on <= (phase_next == PH_OFF) && !s_on;
    end
  end

  // Soft start timer, restarted at every phase change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt_reg <= '0;
    end else if (phase_next != phase_reg) begin
      phase_cnt_reg <= '0;
    end else if (phase_reg == PH_SOFT) begin
      phase_cnt_reg <= phase_cnt_reg + 32'h1;
    end
  end

  // Built-in blanking counts while feedback is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_cnt_reg <= '0;
    end else if (!active || !s_fbh) begin
      blank_cnt_reg <= '0;
    end else if (!blank_reached) begin
      blank_cnt_reg <= blank_cnt_reg + 32'h1;
    end
  end

  // Spike blanking after extended count ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spike_cnt_reg <= '0;
    end else if (!(ext_done && s_fbh && active)) begin
      spike_cnt_reg <= '0;
    end else if (spike_cnt_reg < 32'(SPIKE_CYC_P)) begin
      spike_cnt_reg <= spike_cnt_reg + 32'h1;
    end
  end

  // Input OVP blanking, held off while extended blanking owns the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovp_cnt_reg <= '0;
    end else if (!s_oset || !s_on || (ext_run && ovp_cnt_reg == '0)) begin
      ovp_cnt_reg <= '0;
    end else if (!ovp_qualified) begin
      ovp_cnt_reg <= ovp_cnt_reg + 32'h1;
    end
  end

  // Input OVP latch and over-temperature state survive restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_ovp_latch <= 1'b0;
      otp_reg <= 1'b0;
    end else begin
      input_ovp_latch <= ovp_latch_next;
      if (s_hot) begin
        otp_reg <= 1'b1;
      end else if (s_cool) begin
        otp_reg <= 1'b0;
      end
    end
  end

  // Registered pin switches and done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_switch <= 1'b0;
      discharge_switch <= 1'b0;
      ext_blank_done <= 1'b0;
    end else begin
      charge_switch <= ext_chg;
      discharge_switch <= ext_dis;
      ext_blank_done <= ext_done;
    end
  end

  // APB decode, one wait state per access
  assign bus_access = psel && penable;
  assign bus_done = bus_access && pready;
  assign bus_write = bus_done && pwrite;
  // Status and count are read only; writes there are dropped
  assign hit_ctrl = paddr == CTRL_OFS;
  assign hit_status = paddr == STATUS_OFS;
  assign hit_count = paddr == COUNT_OFS;
  assign hit_any = hit_ctrl || hit_status || hit_count;
  assign status_word = {24'h000000, soft_start, switch_enable, ext_blank_done, otp_reg,
                        input_ovp_latch, cycle_odd, restart_mode};
  assign read_word = hit_ctrl ? {31'h00000000, ctrl_en_reg} :
                     hit_status ? status_word :
                     hit_count ? {23'h000000, ext_count} : 32'h00000000;

  // APB answer and control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl_en_reg <= CTRL_EN_RST;
    end else begin
      pready <= bus_access && !pready;
      pslverr <= bus_access && !pready && !hit_any;
      if (bus_access && !pready && !pwrite) begin
        prdata <= read_word;
      end
      if (bus_write && hit_ctrl) begin
        ctrl_en_reg <= pwdata[CTRL_EN_BIT];
      end
    end
  end
endmodule

/* File: prs_top_assertions.sv */
// Checker for the protection restart sequencer outputs
`timescale 1ns/1ps
module prs_top_checker
  import prs_pkg::*;
#(
  parameter int BLANK_CYC_P = 50,
  parameter int OVP_BLANK_CYC_P = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Comparator flags
  input wire logic supply_on_cmp,
  input wire logic vcc_ovp2_cmp,
  input wire logic feedback_high_cmp,
  input wire logic over_temp_cmp,
  input wire logic ovp_set_cmp,
  input wire logic ovp_clear_cmp,
  // Design outputs
  input wire logic switch_enable,
  input wire logic soft_start,
  input wire logic startup_cell_on,
  input wire logic charge_switch,
  input wire logic discharge_switch,
  input wire prs_pkg::prs_mode_t restart_mode,
  input wire logic cycle_odd,
  input wire logic input_ovp_latch,
  input wire logic ext_blank_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int fb_run;
  int ovp_run;
  // Consecutive high cycles of feedback and pin over-voltage flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_run <= 0;
      ovp_run <= 0;
    end else begin
      fb_run <= feedback_high_cmp ? fb_run + 1 : 0;
      ovp_run <= ovp_set_cmp ? ovp_run + 1 : 0;
    end
  end
  // Faults held long enough to pass the synchroniser while switching
  sequence ovp2_held;
    switch_enable && vcc_ovp2_cmp ##1 vcc_ovp2_cmp [*3];
  endsequence
  sequence heat_held;
    switch_enable && over_temp_cmp ##1 over_temp_cmp [*3];
  endsequence
  ovp_gate_a: assert property (input_ovp_latch |-> !switch_enable)
    else $error("switching while input over-voltage latched");
  heat_gate_a: assert property (restart_mode == PRS_NON_SWITCH |-> !switch_enable)
    else $error("switching in non-switching restart");
  odd_quiet_a: assert property (restart_mode == PRS_ODD_SKIP && cycle_odd |-> !switch_enable)
    else $error("switching in odd skip cycle");
  soft_sw_a: assert property (soft_start |-> switch_enable)
    else $error("soft start without switching");
  pin_excl_a: assert property (!(charge_switch && discharge_switch))
    else $error("charge and discharge together");
  lockout_off_a: assert property ($fell(supply_on_cmp) |-> ##[2:4] (startup_cell_on && !switch_enable))
    else $error("no shutdown after supply lockout");
  ovp2_trip_a: assert property (ovp2_held |-> ##[0:2] restart_mode == PRS_ODD_SKIP)
    else $error("supply over-voltage did not select odd skip");
  heat_trip_a: assert property (heat_held |-> ##[0:2] restart_mode == PRS_NON_SWITCH)
    else $error("over-temperature did not select non-switching");
  ovp_hold_a: assert property (input_ovp_latch && !ovp_clear_cmp && !$past(ovp_clear_cmp)
    && !$past(ovp_clear_cmp, 2) |=> input_ovp_latch)
    else $error("input over-voltage latch cleared without clear flag");
  ovp_blank_a: assert property ($rose(input_ovp_latch) |-> ovp_run >= OVP_BLANK_CYC_P)
    else $error("input over-voltage latch set too early");
  fb_blank_a: assert property ($rose(discharge_switch) && !ext_blank_done
    |-> fb_run >= BLANK_CYC_P)
    else $error("extended blanking before built-in blanking ended");
endmodule
bind prs_top prs_top_checker #(.BLANK_CYC_P(BLANK_CYC_P), .OVP_BLANK_CYC_P(OVP_BLANK_CYC_P)) chk_u (
  .pclk(pclk), .presetn(presetn), .supply_on_cmp(supply_on_cmp), .vcc_ovp2_cmp(vcc_ovp2_cmp),
  .feedback_high_cmp(feedback_high_cmp), .over_temp_cmp(over_temp_cmp),
  .ovp_set_cmp(ovp_set_cmp), .ovp_clear_cmp(ovp_clear_cmp), .switch_enable(switch_enable),
  .soft_start(soft_start), .startup_cell_on(startup_cell_on), .charge_switch(charge_switch),
  .discharge_switch(discharge_switch), .restart_mode(restart_mode), .cycle_odd(cycle_odd),
  .input_ovp_latch(input_ovp_latch), .ext_blank_done(ext_blank_done));

/* File: prs_blank_pin_model.sv */
// Behavioural blanking pin with timing capacitor and external pull
`timescale 1ns/1ps
module prs_blank_pin_model #(
  parameter int TOP = 8
) (
  // Clock
  input wire logic pclk,
  // Pin switches
  input wire logic charge_switch,
  input wire logic discharge_switch,
  // Test controls
  input wire logic slow,
  input wire logic ext_pull,
  // Comparator flags
  output logic blank_upper_cmp,
  output logic blank_lower_cmp,
  output logic ovp_set_cmp,
  output logic ovp_clear_cmp
);
  int lvl = 1;
  logic tick = 1'b0;
  // Pin level steps per tick, idles back to the divider level
  always @(posedge pclk) begin
    tick <= slow ? ~tick : 1'b1;
    if (tick && discharge_switch && lvl > 0) lvl <= lvl - 1;
    else if (tick && charge_switch && lvl < TOP) lvl <= lvl + 1;
    else if (tick && !charge_switch && !discharge_switch && lvl != 1) lvl <= (lvl > 1) ? lvl - 1 : 1;
  end
  // Level comparators; external pull forces over-voltage
  assign blank_upper_cmp = lvl >= TOP;
  assign blank_lower_cmp = lvl == 0;
  assign ovp_set_cmp = ext_pull || lvl >= TOP / 2;
  assign ovp_clear_cmp = !ext_pull && lvl < TOP / 2;
endmodule

/* File: prs_top_tb.sv */
// Self-checking bench for the protection restart sequencer
`timescale 1ns/1ps
module prs_top_tb;
  import prs_pkg::*;
  typedef struct {logic [32:0] e; logic [32:0] m; string nm;} prs_note_t;
  localparam int SOFT = 30;
  localparam int SPIKE = 5;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, look = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, supply_on_cmp = 0, vcc_ovp1_cmp = 0, vcc_ovp2_cmp = 0;
  logic feedback_high_cmp = 0, over_temp_cmp = 0, temp_recover_cmp = 0, slow = 0, ext_pull = 0;
  logic blank_upper_cmp, blank_lower_cmp, ovp_set_cmp, ovp_clear_cmp;
  logic switch_enable, soft_start, startup_cell_on, charge_switch, discharge_switch;
  logic cycle_odd, input_ovp_latch, ext_blank_done;
  prs_mode_t restart_mode;
  prs_note_t notes[$];
  prs_note_t cur;
  logic [32:0] seen;
  int errors = 0, checks_done = 0, n;
  wire [7:0] stat = {restart_mode, cycle_odd, input_ovp_latch, ext_blank_done, switch_enable,
    soft_start, startup_cell_on};
  prs_top #(.BLANK_CYC_P(50), .OVP_BLANK_CYC_P(20), .SPIKE_CYC_P(SPIKE), .SOFT_CYC_P(SOFT)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .supply_on_cmp, .vcc_ovp1_cmp, .vcc_ovp2_cmp, .feedback_high_cmp, .over_temp_cmp,
    .temp_recover_cmp, .blank_upper_cmp, .blank_lower_cmp, .ovp_set_cmp, .ovp_clear_cmp,
    .switch_enable, .soft_start, .startup_cell_on, .charge_switch, .discharge_switch,
    .restart_mode, .cycle_odd, .input_ovp_latch, .ext_blank_done);
  prs_blank_pin_model #(.TOP(8)) pin_u (.pclk, .charge_switch, .discharge_switch, .slow,
    .ext_pull, .blank_upper_cmp, .blank_lower_cmp, .ovp_set_cmp, .ovp_clear_cmp);
  // Clock
  always #2 pclk = ~pclk;
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Status sample noted for the monitor
  task automatic chk(input logic [7:0] e, input logic [7:0] m, input string nm);
    notes.push_back('{{25'h0, e}, {25'h0, m}, nm});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask
  // One APB transfer, answer noted as {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m, input string nm);
    notes.push_back('{e, m, nm});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Idle cycle, so a next call never re-drives psel at once
  endtask
  task automatic sup(input logic v);
    supply_on_cmp <= v;
    wt(6);
  endtask
  task automatic cyc(input logic [7:0] e, input logic [7:0] m, input string nm);
    sup(0);
    sup(1);
    chk(e, m, nm);
  endtask
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor: compare the oldest note when a result appears
  always @(posedge pclk) begin
    if (look === 1'b1 || (psel && penable && pready) === 1'b1) begin
      cur = notes.pop_front();
      seen = look ? {25'h0, stat} : {pslverr, prdata};
      checks_done++;
      if ((seen & cur.m) !== (cur.e & cur.m)) begin
        errors++;
        $display("ERROR %s expected %h seen %h", cur.nm, cur.e & cur.m, seen & cur.m);
      end
    end
  end
  // Watchdog
  initial begin
    wt(30000);
    errors++;
    end_of_test;
  end
  // Main sequence
  initial begin
    void'($urandom(32'hfe5fa196));
    wt(6);
    presetn <= 1'b1;
    wt(1);
    chk(8'h01, 8'hff, "reset outputs");
    apb(0, CTRL_OFS, 32'h0, 33'h1, 33'h1ffffffff, "ctrl reset");
    apb(0, 12'h00c, 32'h0, 33'h100000000, 33'h1ffffffff, "unmapped read");
    apb(1, 12'h010, $urandom, 33'h100000000, 33'h100000000, "unmapped write");
    apb(1, STATUS_OFS, $urandom, 33'h0, 33'h100000000, "status write");
    apb(0, STATUS_OFS, 32'h0, 33'h0, 33'h1ffffffff, "status read");
    apb(1, CTRL_OFS, $urandom & 32'hfffffffe, 33'h0, 33'h100000000, "ctrl clear");
    apb(0, CTRL_OFS, 32'h0, 33'h0, 33'h1ffffffff, "ctrl cleared");
    apb(1, CTRL_OFS, $urandom | 32'h1, 33'h0, 33'h100000000, "ctrl write");
    apb(0, CTRL_OFS, 32'h0, 33'h1, 33'h1ffffffff, "ctrl read");
    sup(1);
    chk(8'h06, 8'hff, "first soft start");
    wt(SOFT);
    chk(8'h04, 8'hff, "running");
    over_temp_cmp <= 1'b1;
    wt(6);
    chk(8'hc0, 8'hff, "heat trip");
    over_temp_cmp <= 1'b0;
    cyc(8'he0, 8'hff, "heat odd");
    cyc(8'hc0, 8'hff, "heat held");
    temp_recover_cmp <= 1'b1;
    cyc(8'he0, 8'hff, "heat odd again");
    cyc(8'h06, 8'hff, "heat resume");
    temp_recover_cmp <= 1'b0;
    wt(SOFT);
    vcc_ovp2_cmp <= 1'b1;
    wt(6);
    vcc_ovp2_cmp <= 1'b0;
    chk(8'h80, 8'hff, "supply ovp trip");
    cyc(8'ha0, 8'hff, "skip odd");
    cyc(8'h86, 8'hff, "skip even");
    wt(SOFT);
    chk(8'h04, 8'hff, "skip released");
    sup(0);
    chk(8'h41, 8'hdf, "undervoltage");
    sup(1);
    chk(8'h46, 8'hdf, "normal restart");
    wt(SOFT);
    chk(8'h04, 8'hdf, "normal released");
    feedback_high_cmp <= 1'b1;
    slow <= 1'b1;
    n = 0;
    while (ext_blank_done !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk(8'h0c, 8'hcc, "ext done before spike");
    apb(0, COUNT_OFS, 32'h0, 33'h100, 33'h1ffffffff, "ext count");
    wt(SPIKE);
    chk(8'h80, 8'hc4, "overload trip");
    feedback_high_cmp <= 1'b0;
    sup(0);
    chk(8'h81, 8'hc9, "lockout clears blanking");
    sup(1);
    chk(8'ha0, 8'hff, "overload odd");
    cyc(8'h86, 8'hff, "overload even");
    wt(SOFT);
    ext_pull <= 1'b1;
    wt(10);
    ext_pull <= 1'b0;
    wt(4);
    chk(8'h04, 8'h14, "short pull ignored");
    ext_pull <= 1'b1;
    wt(30);
    chk(8'h10, 8'h14, "input ovp set");
    cyc(8'h10, 8'h16, "input ovp held");
    ext_pull <= 1'b0;
    wt(6);
    chk(8'h00, 8'h16, "input ovp clear");
    cyc(8'h06, 8'h16, "input ovp restart");
    vcc_ovp1_cmp <= 1'b1;
    feedback_high_cmp <= 1'b1;
    wt(6);
    chk(8'h80, 8'hff, "soft start supply ovp");
    end_of_test;
  end
endmodule
